// *** hw/acrb_pkg.sv ***
/*
 * holds the register map, field layout, reset values and port carriers
 * of the analogue control register bank.
 * assumes a host-side serial control decoder on the same clock that
 * presents one decoded register access at a time.
 */
package acrb_pkg;

	// -----------------------------------------------------------------
	// widths
	// -----------------------------------------------------------------
	localparam int unsigned ADDR_W  = 8;   // register address width
	localparam int unsigned DATA_W  = 16;  // register word width
	localparam int unsigned LVL_W   = 8;   // level register stored bits
	localparam int unsigned REF_W   = 6;   // reference register stored bits
	localparam int unsigned BIAS_W  = 7;   // bias register stored bits
	localparam int unsigned VOL_W   = 6;   // volume code width

	// -----------------------------------------------------------------
	// register addresses
	// -----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] ADDR_RESET_IDENTITY = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_LINE_OUTPUT    = 8'h02;
	localparam logic [ADDR_W-1:0] ADDR_SPEAKER_STAGE  = 8'h03;
	localparam logic [ADDR_W-1:0] ADDR_MIDRAIL_REF    = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_BIAS_GEN       = 8'h05;

	// -----------------------------------------------------------------
	// field positions
	// -----------------------------------------------------------------
	localparam int unsigned LVL_SILENCE_BIT    = 7;  // mute bit of level regs
	localparam int unsigned LVL_ZERO_CROSS_BIT = 6;  // zero-cross select bit
	localparam int unsigned LVL_CODE_MSB       = 5;  // volume code msb
	localparam int unsigned REF_BUF_ENA_BIT    = 5;  // buffer enable
	localparam int unsigned REF_SOFT_START_BIT = 3;  // soft start
	localparam int unsigned REF_DIV_MSB        = 2;  // divider select msb
	localparam int unsigned REF_DIV_LSB        = 1;  // divider select lsb
	localparam int unsigned REF_SLEW_BIT       = 0;  // slew select
	localparam int unsigned BIAS_SOURCE_SELECT_BIT       = 6;  // bias source select
	localparam int unsigned BIAS_STBY_LVL_BIT  = 5;  // standby level
	localparam int unsigned BIAS_STBY_ENA_BIT  = 4;  // standby enable
	localparam int unsigned MASTER_CURRENT_LEVEL_MSB       = 3;  // master level msb
	localparam int unsigned MASTER_CURRENT_LEVEL_LSB       = 2;  // master level lsb
	localparam int unsigned BIAS_NORM_ENA_BIT  = 1;  // normal generator enable
	localparam int unsigned BIAS_START_ENA_BIT = 0;  // start-up generator enable

	// -----------------------------------------------------------------
	// reset values and writable masks
	// -----------------------------------------------------------------
	localparam logic [LVL_W-1:0]  LVL_RESET  = 8'hB9;  // muted, immediate, 0 dB
	localparam logic [REF_W-1:0]  REF_RESET  = 6'h01;  // off, fast slew
	localparam logic [REF_W-1:0]  REF_MASK   = 6'h2F;  // bit 4 has no function
	localparam logic [BIAS_W-1:0] BIAS_RESET = 7'h68;  // start-up src, x1 level
	localparam logic [BIAS_W-1:0] BIAS_MASK  = 7'h7F;  // all stored bits live
	localparam logic [DATA_W-1:0] READ_ZERO  = 16'h0000;

	// -----------------------------------------------------------------
	// decoded codes
	// -----------------------------------------------------------------
	localparam logic [1:0] DIV_OFF     = 2'h0;  // reference disabled
	localparam logic [1:0] DIV_NORMAL  = 2'h1;  // normal divider
	localparam logic [1:0] DIV_STANDBY = 2'h2;  // low-power standby divider
	localparam logic [1:0] DIV_FAST    = 2'h3;  // fast start-up divider

	localparam logic [1:0] LVL_HALF      = 2'h0;  // x0.5
	localparam logic [1:0] LVL_3QUARTER  = 2'h1;  // x0.75
	localparam logic [1:0] LVL_UNITY     = 2'h2;  // x1
	localparam logic [1:0] LVL_ONE_HALF  = 2'h3;  // x1.5

	// effective bias scale driven to the bias generator
	typedef enum logic [2:0] {
		ACRB_SCALE_QUARTER,
		ACRB_SCALE_HALF,
		ACRB_SCALE_3QUARTER,
		ACRB_SCALE_UNITY,
		ACRB_SCALE_ONE_HALF
	} acrb_scale_t;

	// -----------------------------------------------------------------
	// carriers
	// -----------------------------------------------------------------
	// one decoded access from the serial control decoder
	typedef struct packed {
		logic              wr;     // write strobe, one cycle
		logic              rd;     // read strobe, one cycle
		logic [ADDR_W-1:0] addr;   // register address
		logic [DATA_W-1:0] wdata;  // write word
	} acrb_req_t;

	// read answer
	typedef struct packed {
		logic              valid;  // one cycle after the read strobe
		logic [DATA_W-1:0] rdata;  // read word
	} acrb_rsp_t;

	// one-hot reference divider selection
	typedef struct packed {
		logic off;
		logic normal;
		logic standby;
		logic fast;
	} acrb_div_t;

endpackage

// *** hw/acrb_field_reg.sv ***
/*
 * holds one stored register of the bank with reset, soft reset and masked write.
 * assumes the write strobe and soft reset come from logic on the same clock.
 */
module acrb_field_reg #(
	parameter int unsigned        WIDTH = 8,
	parameter logic [WIDTH-1:0]   RESET = '0,
	parameter logic [WIDTH-1:0]   MASK  = '1
) (
	input  wire logic             clk_sys,
	input  wire logic             sys_rst,
	input  wire logic             soft_rst,
	input  wire logic             wr_en,
	input  wire logic [WIDTH-1:0] wdata,
	output logic      [WIDTH-1:0] q
);

	logic [WIDTH-1:0] value_reg;   // stored bits
	logic [WIDTH-1:0] value_next;  // next stored bits

	// -----------------------------------------------------------------
	// next value
	// -----------------------------------------------------------------
	// soft reset wins over a write; bits outside the mask stay zero
	always_comb begin
		value_next = value_reg;
		if (soft_rst) begin
			value_next = RESET;
		end else if (wr_en) begin
			value_next = wdata & MASK;
		end
	end

	// register only
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			value_reg <= RESET;
		end else begin
			value_reg <= value_next;
		end
	end

	assign q = value_reg;

endmodule

// *** hw/acrb_bank.sv ***
/*
 * holds the analogue control register bank: identity/reset word, line
 * output and speaker stage levels, mid-rail reference and bias settings.
 * assumes a serial control decoder on clk_sys presenting decoded accesses,
 * zero-cross detector levels arriving asynchronously from the analogue side,
 * and line output enable and clamp controls from other registers on clk_sys.
 */
module acrb_bank #(
	parameter logic [15:0] FAMILY_ID = 16'h5A5A  // arbitrary identity value
) (
	input  wire logic                    clk_sys,
	input  wire logic                    sys_rst,
	input  wire acrb_pkg::acrb_req_t     req,
	output acrb_pkg::acrb_rsp_t          rsp,
	input  wire logic                    line_zero_cross,
	input  wire logic                    speaker_zero_cross,
	input  wire logic                    line_output_enable,
	input  wire logic                    clamp_request,
	input  wire logic                    clamp_low_resistance,
	output logic                         line_output_silence,
	output logic [acrb_pkg::VOL_W-1:0]   line_output_level_code,
	output logic                         speaker_stage_silence,
	output logic [acrb_pkg::VOL_W-1:0]   speaker_stage_level_code,
	output logic                         reference_buffer_enable,
	output logic                         reference_soft_start,
	output acrb_pkg::acrb_div_t          reference_divider_select,
	output logic                         reference_slew_select,
	output logic                         bias_source_select,
	output acrb_pkg::acrb_scale_t        bias_scale,
	output logic                         normal_current_enable,
	output logic                         startup_current_enable,
	output logic                         clamp_active,
	output logic                         clamp_low_res_active
);

	// -----------------------------------------------------------------
	// address decode
	// -----------------------------------------------------------------
	logic                          hit_id;     // address zero
	logic                          hit_line;   // line output level
	logic                          hit_spk;    // speaker stage level
	logic                          hit_ref;    // reference control
	logic                          hit_bias;   // bias control
	logic                          soft_rst;   // write to address zero
	logic [acrb_pkg::LVL_W-1:0]    line_q;     // stored line bits
	logic [acrb_pkg::LVL_W-1:0]    spk_q;      // stored speaker bits
	logic [acrb_pkg::REF_W-1:0]    ref_q;      // stored reference bits
	logic [acrb_pkg::BIAS_W-1:0]   bias_q;     // stored bias bits

	assign hit_id   = req.addr == acrb_pkg::ADDR_RESET_IDENTITY;
	assign hit_line = req.addr == acrb_pkg::ADDR_LINE_OUTPUT;
	assign hit_spk  = req.addr == acrb_pkg::ADDR_SPEAKER_STAGE;
	assign hit_ref  = req.addr == acrb_pkg::ADDR_MIDRAIL_REF;
	assign hit_bias = req.addr == acrb_pkg::ADDR_BIAS_GEN;
	assign soft_rst = req.wr & hit_id;

	// -----------------------------------------------------------------
	// stored registers
	// -----------------------------------------------------------------
	// line output level: silence, zero-cross select, volume code
	acrb_field_reg #(
		.WIDTH (acrb_pkg::LVL_W),
		.RESET (acrb_pkg::LVL_RESET)
	) u_line (
		.clk_sys  (clk_sys),
		.sys_rst  (sys_rst),
		.soft_rst (soft_rst),
		.wr_en    (req.wr & hit_line),
		.wdata    (req.wdata[acrb_pkg::LVL_W-1:0]),
		.q        (line_q)
	);

	// speaker stage level: same layout as the line output
	acrb_field_reg #(
		.WIDTH (acrb_pkg::LVL_W),
		.RESET (acrb_pkg::LVL_RESET)
	) u_spk (
		.clk_sys  (clk_sys),
		.sys_rst  (sys_rst),
		.soft_rst (soft_rst),
		.wr_en    (req.wr & hit_spk),
		.wdata    (req.wdata[acrb_pkg::LVL_W-1:0]),
		.q        (spk_q)
	);

	// reference control; bit 4 masked off
	acrb_field_reg #(
		.WIDTH (acrb_pkg::REF_W),
		.RESET (acrb_pkg::REF_RESET),
		.MASK  (acrb_pkg::REF_MASK)
	) u_ref (
		.clk_sys  (clk_sys),
		.sys_rst  (sys_rst),
		.soft_rst (soft_rst),
		.wr_en    (req.wr & hit_ref),
		.wdata    (req.wdata[acrb_pkg::REF_W-1:0]),
		.q        (ref_q)
	);

	// bias control
	acrb_field_reg #(
		.WIDTH (acrb_pkg::BIAS_W),
		.RESET (acrb_pkg::BIAS_RESET),
		.MASK  (acrb_pkg::BIAS_MASK)
	) u_bias (
		.clk_sys  (clk_sys),
		.sys_rst  (sys_rst),
		.soft_rst (soft_rst),
		.wr_en    (req.wr & hit_bias),
		.wdata    (req.wdata[acrb_pkg::BIAS_W-1:0]),
		.q        (bias_q)
	);

	// -----------------------------------------------------------------
	// read path
	// -----------------------------------------------------------------
	acrb_pkg::acrb_rsp_t rsp_reg;   // registered answer
	acrb_pkg::acrb_rsp_t rsp_next;  // next answer

	// upper bits of narrow registers read as zero
	always_comb begin
		rsp_next.valid = req.rd;
		rsp_next.rdata = acrb_pkg::READ_ZERO;
		if (req.rd) begin
			if (hit_id) begin
				rsp_next.rdata = FAMILY_ID;
			end else if (hit_line) begin
				rsp_next.rdata[acrb_pkg::LVL_W-1:0] = line_q;
			end else if (hit_spk) begin
				rsp_next.rdata[acrb_pkg::LVL_W-1:0] = spk_q;
			end else if (hit_ref) begin
				rsp_next.rdata[acrb_pkg::REF_W-1:0] = ref_q;
			end else if (hit_bias) begin
				rsp_next.rdata[acrb_pkg::BIAS_W-1:0] = bias_q;
			end
		end
	end

	// register only
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			rsp_reg <= '0;
		end else begin
			rsp_reg <= rsp_next;
		end
	end

	assign rsp = rsp_reg;

	// -----------------------------------------------------------------
	// zero-cross synchronisers
	// -----------------------------------------------------------------
	logic [2:0] line_zc_reg;  // [0] meta, [1] safe, [2] history
	logic [2:0] spk_zc_reg;   // same for the speaker stage
	logic [2:0] line_zc_next;
	logic [2:0] spk_zc_next;
	logic       line_zc_event;  // rising edge of the synced level
	logic       spk_zc_event;

	// shift in the asynchronous detector levels
	always_comb begin
		line_zc_next = {line_zc_reg[1:0], line_zero_cross};
		spk_zc_next  = {spk_zc_reg[1:0], speaker_zero_cross};
	end

	// register only
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			line_zc_reg <= '0;
			spk_zc_reg  <= '0;
		end else begin
			line_zc_reg <= line_zc_next;
			spk_zc_reg  <= spk_zc_next;
		end
	end

	// edge detection looks only at the second and third stages
	assign line_zc_event = line_zc_reg[1] & ~line_zc_reg[2];
	assign spk_zc_event  = spk_zc_reg[1] & ~spk_zc_reg[2];

	// -----------------------------------------------------------------
	// applied levels and decoded outputs
	// -----------------------------------------------------------------
	typedef struct packed {
		logic                       line_sil;
		logic [acrb_pkg::VOL_W-1:0] line_code;
		logic                       spk_sil;
		logic [acrb_pkg::VOL_W-1:0] spk_code;
		logic                       buf_ena;
		logic                       soft_start;
		acrb_pkg::acrb_div_t        div;
		logic                       slew;
		logic                       src;
		acrb_pkg::acrb_scale_t      scale;
		logic                       norm_ena;
		logic                       start_ena;
		logic                       clamp;
		logic                       clamp_low;
	} acrb_out_t;

	acrb_out_t out_reg;   // driven outputs
	acrb_out_t out_next;  // next outputs

	// volume applies now or at the next zero crossing; mute is immediate
	always_comb begin
		out_next          = out_reg;
		out_next.line_sil = line_q[acrb_pkg::LVL_SILENCE_BIT];
		out_next.spk_sil  = spk_q[acrb_pkg::LVL_SILENCE_BIT];
		if (!line_q[acrb_pkg::LVL_ZERO_CROSS_BIT] || line_zc_event) begin
			out_next.line_code = line_q[acrb_pkg::LVL_CODE_MSB:0];
		end
		if (!spk_q[acrb_pkg::LVL_ZERO_CROSS_BIT] || spk_zc_event) begin
			out_next.spk_code = spk_q[acrb_pkg::LVL_CODE_MSB:0];
		end
		if (soft_rst) begin
			out_next.line_code = acrb_pkg::LVL_RESET[acrb_pkg::LVL_CODE_MSB:0];
			out_next.spk_code  = acrb_pkg::LVL_RESET[acrb_pkg::LVL_CODE_MSB:0];
		end
		out_next.buf_ena    = ref_q[acrb_pkg::REF_BUF_ENA_BIT];
		out_next.soft_start = ref_q[acrb_pkg::REF_SOFT_START_BIT];
		// one-hot divider decode
		out_next.div = '0;
		unique case (ref_q[acrb_pkg::REF_DIV_MSB:acrb_pkg::REF_DIV_LSB])
			acrb_pkg::DIV_OFF:     out_next.div.off     = 1'b1;
			acrb_pkg::DIV_NORMAL:  out_next.div.normal  = 1'b1;
			acrb_pkg::DIV_STANDBY: out_next.div.standby = 1'b1;
			acrb_pkg::DIV_FAST:    out_next.div.fast    = 1'b1;
		endcase
		out_next.slew = ref_q[acrb_pkg::REF_SLEW_BIT];
		out_next.src  = bias_q[acrb_pkg::BIAS_SOURCE_SELECT_BIT];
		// standby level overrides the master level when enabled
		if (bias_q[acrb_pkg::BIAS_STBY_ENA_BIT]) begin
			out_next.scale = bias_q[acrb_pkg::BIAS_STBY_LVL_BIT] ?
				acrb_pkg::ACRB_SCALE_QUARTER : acrb_pkg::ACRB_SCALE_HALF;
		end else begin
			unique case (bias_q[acrb_pkg::MASTER_CURRENT_LEVEL_MSB:acrb_pkg::MASTER_CURRENT_LEVEL_LSB])
				acrb_pkg::LVL_HALF:     out_next.scale = acrb_pkg::ACRB_SCALE_HALF;
				acrb_pkg::LVL_3QUARTER: out_next.scale = acrb_pkg::ACRB_SCALE_3QUARTER;
				acrb_pkg::LVL_UNITY:    out_next.scale = acrb_pkg::ACRB_SCALE_UNITY;
				acrb_pkg::LVL_ONE_HALF: out_next.scale = acrb_pkg::ACRB_SCALE_ONE_HALF;
			endcase
		end
		out_next.norm_ena  = bias_q[acrb_pkg::BIAS_NORM_ENA_BIT];
		out_next.start_ena = bias_q[acrb_pkg::BIAS_START_ENA_BIT];
		// clamp needs the buffer and a disabled line output
		out_next.clamp = clamp_request & ~line_output_enable &
			ref_q[acrb_pkg::REF_BUF_ENA_BIT];
		out_next.clamp_low = clamp_low_resistance;
	end

	// register only; reset values match the stored defaults
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			out_reg           <= '0;
			out_reg.line_sil  <= 1'b1;
			out_reg.line_code <= acrb_pkg::LVL_RESET[acrb_pkg::LVL_CODE_MSB:0];
			out_reg.spk_sil   <= 1'b1;
			out_reg.spk_code  <= acrb_pkg::LVL_RESET[acrb_pkg::LVL_CODE_MSB:0];
			out_reg.div.off   <= 1'b1;
			out_reg.slew      <= 1'b1;
			out_reg.src       <= 1'b1;
			out_reg.scale     <= acrb_pkg::ACRB_SCALE_UNITY;
		end else begin
			out_reg <= out_next;
		end
	end

	// -----------------------------------------------------------------
	// output wiring
	// -----------------------------------------------------------------
	assign line_output_silence      = out_reg.line_sil;
	assign line_output_level_code   = out_reg.line_code;
	assign speaker_stage_silence    = out_reg.spk_sil;
	assign speaker_stage_level_code = out_reg.spk_code;
	assign reference_buffer_enable  = out_reg.buf_ena;
	assign reference_soft_start     = out_reg.soft_start;
	assign reference_divider_select = out_reg.div;
	assign reference_slew_select    = out_reg.slew;
	assign bias_source_select       = out_reg.src;
	assign bias_scale               = out_reg.scale;
	assign normal_current_enable    = out_reg.norm_ena;
	assign startup_current_enable   = out_reg.start_ena;
	assign clamp_active             = out_reg.clamp;
	assign clamp_low_res_active     = out_reg.clamp_low;

endmodule

// *** verif/acrb_bank_props.sv ***
/*
 * concurrent checks on the ports of the analogue control register bank.
 * assumes one clock, an async active-high reset, and binding onto acrb_bank.
 */
module acrb_bank_props #(
	parameter logic [15:0] FAMILY_ID = 16'h0000  // arbitrary identity value
) (
	input wire logic                        clk_sys,
	input wire logic                        sys_rst,
	input wire acrb_pkg::acrb_req_t         req,
	input wire acrb_pkg::acrb_rsp_t         rsp,
	input wire logic                        line_output_enable,
	input wire logic                        clamp_request,
	input wire logic                        line_output_silence,
	input wire logic [acrb_pkg::VOL_W-1:0]  line_output_level_code,
	input wire logic                        reference_buffer_enable,
	input wire logic                        reference_soft_start,
	input wire acrb_pkg::acrb_div_t         reference_divider_select,
	input wire logic                        reference_slew_select,
	input wire logic                        bias_source_select,
	input wire acrb_pkg::acrb_scale_t       bias_scale,
	input wire logic                        normal_current_enable,
	input wire logic                        startup_current_enable,
	input wire logic                        clamp_active
);
	// -----------------------------------------------------------------
	// clocking and access sequences
	// -----------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	// write or read strobe to one address
	sequence s_wr(logic [7:0] a);
		req.wr && req.addr == a;
	endsequence
	sequence s_rd(logic [7:0] a);
		req.rd && req.addr == a;
	endsequence

	// expected bias scale from the stored bias bits
	function automatic acrb_pkg::acrb_scale_t exp_scale(logic [6:0] b);
		if (b[4])
			return b[5] ? acrb_pkg::ACRB_SCALE_QUARTER : acrb_pkg::ACRB_SCALE_HALF;
		return acrb_pkg::acrb_scale_t'(3'(b[3:2]) + 3'h1);
	endfunction

	// -----------------------------------------------------------------
	// assertions
	// -----------------------------------------------------------------
	a_read_answer_due: assert property (req.rd |=> rsp.valid)
		else $error("read answer missing");
	a_no_stray_answer: assert property (!req.rd |=> !rsp.valid)
		else $error("answer without read");
	a_identity_read_word: assert property (s_rd(8'h00) |=> rsp.rdata == FAMILY_ID)
		else $error("identity word wrong");
	a_unmapped_read_zero: assert property (s_rd(8'h01) |=> rsp.rdata == 16'h0000)
		else $error("unmapped read not zero");
	a_soft_reset_defaults: assert property (s_wr(8'h00) |-> ##2 (line_output_silence
		&& line_output_level_code == 6'h39 && reference_divider_select.off
		&& reference_slew_select && bias_source_select && !reference_buffer_enable
		&& bias_scale == acrb_pkg::ACRB_SCALE_UNITY && !normal_current_enable))
		else $error("defaults not restored");
	a_level_immediate_apply: assert property (s_wr(8'h02) ##0 !req.wdata[6]
		##1 !(req.wr && req.addr == 8'h00) |=> line_output_level_code == $past(req.wdata[5:0], 2)
		&& line_output_silence == $past(req.wdata[7], 2))
		else $error("line level not applied");
	a_ref_field_follow: assert property (s_wr(8'h04) |-> ##2
		reference_buffer_enable == $past(req.wdata[5], 2)
		&& reference_soft_start == $past(req.wdata[3], 2)
		&& reference_slew_select == $past(req.wdata[0], 2))
		else $error("reference fields wrong");
	a_divider_one_hot: assert property (s_wr(8'h04) |-> ##2
		reference_divider_select == 4'h8 >> $past(req.wdata[2:1], 2))
		else $error("divider decode wrong");
	a_bias_field_follow: assert property (s_wr(8'h05) |-> ##2
		bias_scale == exp_scale($past(req.wdata[6:0], 2))
		&& bias_source_select == $past(req.wdata[6], 2)
		&& normal_current_enable == $past(req.wdata[1], 2)
		&& startup_current_enable == $past(req.wdata[0], 2))
		else $error("bias fields wrong");
	a_clamp_needs_disable: assert property (clamp_active |->
		$past(clamp_request) && !$past(line_output_enable))
		else $error("clamp while output enabled");
endmodule

bind acrb_bank acrb_bank_props #(.FAMILY_ID(FAMILY_ID)) props_u (.clk_sys, .sys_rst, .req, .rsp,
	.line_output_enable, .clamp_request, .line_output_silence, .line_output_level_code,
	.reference_buffer_enable, .reference_soft_start, .reference_divider_select,
	.reference_slew_select, .bias_source_select, .bias_scale, .normal_current_enable,
	.startup_current_enable, .clamp_active);

// *** verif/acrb_host_model.sv ***
/*
 * host side of the register port: issues decoded writes and reads.
 * assumes the bank answers a read exactly one cycle after the strobe.
 */
module acrb_host_model (
	input  wire logic                 clk_sys,
	output acrb_pkg::acrb_req_t       req,
	input  wire acrb_pkg::acrb_rsp_t  rsp
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle port at time zero
	initial req = '0;

	// one-cycle write strobe; released fields show a changed pattern
	task automatic wr_word(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		req.wr <= 1'b1;
		req.addr <= a;
		req.wdata <= d;
		@(posedge clk_sys);
		req.wr <= 1'b0;
		req.addr <= ~a;
		req.wdata <= ~d;
	endtask

	// one-cycle read strobe, answer taken once the strobe edge has settled
	task automatic rd_word(input logic [7:0] a, output logic [15:0] d, output logic v);
		@(posedge clk_sys);
		req.rd <= 1'b1;
		req.addr <= a;
		@(posedge clk_sys);
		req.rd <= 1'b0;
		req.addr <= ~a;
		#1;
		d = rsp.rdata;
		v = rsp.valid;
	endtask
endmodule

// *** verif/acrb_bank_tb.sv ***
/*
 * self-checking bench for the analogue control register bank.
 * assumes the host model drives the register port; bench drives the rest.
 */
module acrb_bank_tb;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [15:0] FAMILY_ID = 16'hC3A5;  // arbitrary identity value

	logic clk_sys;
	logic sys_rst;
	logic line_zero_cross, speaker_zero_cross, line_output_enable;
	logic clamp_request, clamp_low_resistance;
	acrb_pkg::acrb_req_t req;
	acrb_pkg::acrb_rsp_t rsp;
	logic line_output_silence, speaker_stage_silence, reference_buffer_enable;
	logic [5:0] line_output_level_code, speaker_stage_level_code;
	logic reference_soft_start, reference_slew_select, bias_source_select;
	acrb_pkg::acrb_div_t reference_divider_select;
	acrb_pkg::acrb_scale_t bias_scale;
	logic normal_current_enable, startup_current_enable, clamp_active, clamp_low_res_active;
	int err_total = 0;
	int tests_run = 0;
	int cycles = 0;

	acrb_host_model host_u (.clk_sys, .req, .rsp);
	acrb_bank #(.FAMILY_ID(FAMILY_ID)) dut_u (.clk_sys, .sys_rst, .req, .rsp,
		.line_zero_cross, .speaker_zero_cross, .line_output_enable, .clamp_request,
		.clamp_low_resistance, .line_output_silence, .line_output_level_code,
		.speaker_stage_silence, .speaker_stage_level_code, .reference_buffer_enable,
		.reference_soft_start, .reference_divider_select, .reference_slew_select,
		.bias_source_select, .bias_scale, .normal_current_enable, .startup_current_enable,
		.clamp_active, .clamp_low_res_active);

	// 250 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	// -----------------------------------------------------------------
	// helpers
	// -----------------------------------------------------------------
	task automatic wrap_up();
		if (err_total == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
		logic [15:0] d;
		logic v;
		host_u.rd_word(a, d, v);
		chk("read valid", 16'h0001, {15'h0, v});
		chk("read word", e, d);
	endtask

	// let a write reach the registered outputs
	task automatic settle();
		repeat (2) @(posedge clk_sys);
		#1;
	endtask

	// packed views of the output groups
	function automatic logic [15:0] ref_out();
		return {reference_buffer_enable, reference_soft_start,
			4'(reference_divider_select), reference_slew_select};
	endfunction
	function automatic logic [15:0] bias_out();
		return {bias_source_select, 3'(bias_scale), normal_current_enable,
			startup_current_enable};
	endfunction

	// -----------------------------------------------------------------
	// scenarios
	// -----------------------------------------------------------------
	// reset values at outputs and through reads
	task automatic t_defaults();
		logic [7:0] adr [8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'hFF};
		logic [15:0] exp [8] = '{FAMILY_ID, 16'h0, 16'h00B9, 16'h00B9, 16'h0001, 16'h0068,
			16'h0, 16'h0};
		chk("line out", 16'h0079, {line_output_silence, line_output_level_code});
		chk("speaker out", 16'h0079, {speaker_stage_silence, speaker_stage_level_code});
		chk("ref out", 16'h0011, ref_out());
		chk("bias out", 16'h002C, bias_out());
		for (int i = 0; i < 8; i++)
			rd_chk(adr[i], exp[i]);
	endtask

	// all ones written, zero-cross bit clear on levels: dead bits read zero, live fields reach outputs
	task automatic t_full_write();
		for (int a = 1; a < 6; a++)
			host_u.wr_word(8'(a), (a == 2 || a == 3) ? 16'hFFBF : 16'hFFFF);
		settle();
		chk("line out", 16'h007F, {line_output_silence, line_output_level_code});
		chk("ref out", 16'h0063, ref_out());
		chk("bias out", 16'h0023, bias_out());
		rd_chk(8'h01, 16'h0000);
		rd_chk(8'h02, 16'h00BF);
		rd_chk(8'h04, 16'h002F);
		rd_chk(8'h05, 16'h007F);
	endtask

	// every divider code and every bias level code
	task automatic t_decodes();
		for (int i = 0; i < 4; i++) begin
			host_u.wr_word(8'h04, {13'h0, 2'(i), 1'b0});
			host_u.wr_word(8'h05, {12'h0, 2'(i), 2'b00});
			settle();
			chk("divider", 16'h0008 >> i, 16'(reference_divider_select));
			chk("scale", 16'(i + 1), 16'(bias_scale));
		end
		host_u.wr_word(8'h05, 16'h0010);
		settle();
		chk("scale", 16'(acrb_pkg::ACRB_SCALE_HALF), 16'(bias_scale));
	endtask

	// any write to address zero restores defaults
	task automatic t_soft_reset();
		host_u.wr_word(8'h02, 16'h0000);
		host_u.wr_word(8'h00, 16'h1234);
		settle();
		t_defaults();
	endtask

	// zero-cross select holds a new code until a crossing arrives
	task automatic t_zero_cross(input int s);
		host_u.wr_word(8'(2 + s), 16'h0005);
		settle();
		chk("level", 16'h0005, s ? speaker_stage_level_code : line_output_level_code);
		host_u.wr_word(8'(2 + s), 16'h0050);
		repeat (6) @(posedge clk_sys);
		chk("held level", 16'h0005, s ? speaker_stage_level_code : line_output_level_code);
		if (s)
			speaker_zero_cross <= 1'b1;
		else
			line_zero_cross <= 1'b1;
		repeat (6) @(posedge clk_sys);
		chk("crossed level", 16'h0010, s ? speaker_stage_level_code : line_output_level_code);
		speaker_zero_cross <= 1'b0;
		line_zero_cross <= 1'b0;
	endtask

	// clamp only while the line output is disabled
	task automatic t_clamp();
		host_u.wr_word(8'h04, 16'h0020);
		@(posedge clk_sys);
		clamp_request <= 1'b1;
		clamp_low_resistance <= 1'b1;
		settle();
		chk("clamp", 16'h0003, {14'h0, clamp_low_res_active, clamp_active});
		@(posedge clk_sys);
		line_output_enable <= 1'b1;
		settle();
		chk("clamp", 16'h0000, {15'h0, clamp_active});
	endtask

	// hang guard
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			wrap_up();
		end
	end

	// main sequence
	initial begin
		sys_rst = 1'b1;
		{line_zero_cross, speaker_zero_cross, line_output_enable, clamp_request,
			clamp_low_resistance} = '0;
		repeat (8) @(posedge clk_sys);
		sys_rst <= 1'b0;
		settle();
		t_defaults();
		t_full_write();
		t_decodes();
		t_soft_reset();
		t_zero_cross(0);
		t_zero_cross(1);
		t_clamp();
		wrap_up();
	end
endmodule
